//--- bench/tb_wtc_counter.sv
// self-checking bench for the working time counter
`timescale 1ns/100ps
`default_nettype none
`include "wtc_cfg.svh"
module tb_wtc_counter;
  logic        clk, rstn, cyc, stb, we, bret, cwr, rwr, rval, tx, txv, ans_en, ans_v, iwr, ival, rdreq;
  logic        ack, send, wide, asend, aval;
  logic [7:0]  adr, intin;
  logic [31:0] wdat, rd, rdat, cval, sval, last_v;
  int          failures, n_compared, n_sent, n_req, n_al;
  wtc_counter #(.SEC_CYC(4), .WAIT_CYC(8)) wtc_counter_inst (
    .I_REF_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rd), .I_BUS_RETURN(bret),
    .I_IN_OBJ_WR(iwr), .I_IN_OBJ_VAL(ival), .I_INT_INPUTS(intin), .I_CNT_OBJ_WR(cwr), .I_CNT_OBJ_VAL(cval),
    .I_RST_OBJ_WR(rwr), .I_RST_OBJ_VAL(rval), .O_IN_READ_REQ(rdreq), .O_CNT_SEND(send), .O_CNT_VAL(sval),
    .O_CNT_WIDE(wide), .O_ALARM_SEND(asend), .O_ALARM_VAL(aval));
  wtc_bus_model wtc_bus_model_inst (.i_clk(clk), .i_rstn(rstn), .i_read_req(rdreq), .i_answer_en(ans_en),
    .i_answer_val(ans_v), .i_tx(tx), .i_tx_val(txv), .o_wr(iwr), .o_val(ival));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (send === 1'b1) n_sent <= n_sent + 1;
    if (send === 1'b1) last_v <= sval;
    if (rdreq === 1'b1) n_req <= n_req + 1;
    if (asend === 1'b1) n_al <= n_al + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rdat = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rdat, e);
  endtask : rchk
  task automatic go(input logic [31:0] c);
    wb(1'b1, `WTC_OFF_CTRL, c | 32'h8000_0000);
  endtask : go
  // k: 0 input telegram, 1 counter overwrite, 2 reset object, 3 bus return
  task automatic obj(input int k, input logic [31:0] v);
    cval <= v;
    rval <= v[0];
    txv  <= v[0];
    {tx, cwr, rwr, bret} <= {k == 0, k == 1, k == 2, k == 3};
    @(posedge clk);
    {tx, cwr, rwr, bret} <= 4'h0;
    cval <= ~v;
    rval <= ~v[0];
    repeat (3) @(posedge clk);
  endtask : obj
  task automatic t_defaults();
    rchk(`WTC_OFF_CTRL, 32'h10);
    wb(1'b1, `WTC_OFF_START, 32'h0);
    rchk(`WTC_OFF_START, 32'h2710);
    rchk(`WTC_OFF_LIMIT, 32'h3e8);
    rchk(8'hfc, 32'h0);
  endtask : t_defaults
  task automatic t_down();
    wb(1'b1, `WTC_OFF_START, 32'h5);
    // seconds, send on change and after return, alarm on elapse
    wb(1'b1, `WTC_OFF_CTRL, 32'h0000_4480);
    obj(3, 32'h0);
    repeat (3) @(posedge clk);
    check(last_v, 32'h5);
    rchk(`WTC_OFF_COUNT, 32'h5);
    obj(0, 32'h1);
    repeat (40) @(posedge clk);
    rchk(`WTC_OFF_COUNT, 32'h0);
    check(last_v, 32'h0);
    check({31'h0, aval}, 32'h1);
    check(32'(n_al), 32'h1);
  endtask : t_down
  task automatic t_up();
    wb(1'b1, `WTC_OFF_LIMIT, 32'h3);
    obj(0, 32'h0);
    go(32'h24);
    repeat (40) @(posedge clk);
    rchk(`WTC_OFF_COUNT, 32'h0);
    check({31'h0, wide}, 32'h1);
    go(32'h26);
    repeat (40) @(posedge clk);
    rchk(`WTC_OFF_COUNT, 32'h3);
    go(32'h44);
    obj(1, 32'h64);
    rchk(`WTC_OFF_COUNT, 32'h3);
    obj(1, 32'h2);
    rchk(`WTC_OFF_COUNT, 32'h2);
    wb(1'b1, `WTC_OFF_CTRL, 32'h4);
    obj(1, 32'h1);
    rchk(`WTC_OFF_COUNT, 32'h2);
  endtask : t_up
  task automatic t_reload();
    // keep value over return, reset object fires on a received on
    wb(1'b1, `WTC_OFF_CTRL, 32'h0004_1804);
    obj(3, 32'h0);
    rchk(`WTC_OFF_COUNT, 32'h2);
    obj(2, 32'h0);
    rchk(`WTC_OFF_COUNT, 32'h2);
    obj(2, 32'h1);
    rchk(`WTC_OFF_COUNT, 32'h0);
    go(32'h0000_2840);
    obj(1, 32'h2);
    obj(2, 32'h0);
    rchk(`WTC_OFF_COUNT, 32'h5);
  endtask : t_reload
  task automatic t_internal();
    int s0;
    wb(1'b1, `WTC_OFF_LIMIT, 32'h6);
    wb(1'b1, `WTC_OFF_INTERVAL, 32'h2);
    intin <= 8'h08;
    s0 = n_sent;
    go(32'h0018_0105);
    repeat (50) @(posedge clk);
    rchk(`WTC_OFF_COUNT, 32'h6);
    check(last_v, 32'h6);
    check(32'(n_sent - s0), 32'h4);
    go(32'h0018_0107);
    repeat (40) @(posedge clk);
    rchk(`WTC_OFF_COUNT, 32'h0);
  endtask : t_internal
  task automatic t_read();
    int r0;
    obj(0, 32'h1);
    r0 = n_req;
    go(32'h0002_0000);
    repeat (60) @(posedge clk);
    rchk(`WTC_OFF_COUNT, 32'h5);
    check(32'(n_req - r0), 32'h1);
    ans_en <= 1'b1;
    ans_v  <= 1'b1;
    go(32'h0002_0000);
    repeat (60) @(posedge clk);
    rchk(`WTC_OFF_COUNT, 32'h0);
  endtask : t_read
  task automatic finish_test();
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    {cyc, stb, we, bret, cwr, rwr, rval, tx, txv, ans_en, ans_v} = '0;
    {adr, intin, wdat, cval, last_v} = '0;
    {failures, n_compared, n_sent, n_req, n_al} = '0;
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_down();
    t_up();
    t_reload();
    t_internal();
    t_read();
    finish_test();
  end
  initial begin
    #40000;
    failures++;
    finish_test();
  end
endmodule : tb_wtc_counter
`default_nettype wire

//--- bench/wtc_bus_model.sv
// bus partner: input object telegrams and answers to read requests
`timescale 1ns/100ps
`default_nettype none
module wtc_bus_model (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_read_req,
  input  wire logic i_answer_en,
  input  wire logic i_answer_val,
  input  wire logic i_tx,
  input  wire logic i_tx_val,
  output logic      o_wr,
  output logic      o_val
);
  logic [1:0] dly_r;
  // a disabled answer never comes, so the device must fall back on its own
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) dly_r <= 2'h0;
    else if (i_read_req && i_answer_en) dly_r <= 2'h3;
    else if (dly_r != 2'h0) dly_r <= dly_r - 2'h1;
  end
  // between telegrams the value line toggles, so a stale value is never trusted
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wr  <= 1'b0;
      o_val <= 1'b0;
    end else begin
      o_wr  <= i_tx || dly_r == 2'h1;
      o_val <= i_tx ? i_tx_val : (dly_r == 2'h1) ? i_answer_val : ~o_val;
    end
  end
endmodule : wtc_bus_model
`default_nettype wire

//--- bench/wtc_counter_checker.sv
// port assertions for the working time counter
`timescale 1ns/100ps
`default_nettype none
`include "wtc_cfg.svh"
module wtc_counter_checker #(
  parameter int unsigned SEC_CYC  = 4,
  parameter int unsigned WAIT_CYC = 8
) (
  input wire logic        I_REF_CLK,
  input wire logic        I_RSTN,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [7:0]  I_WB_ADR,
  input wire logic [3:0]  I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic        O_IN_READ_REQ,
  input wire logic        O_CNT_SEND,
  input wire logic [31:0] O_CNT_VAL,
  input wire logic        O_CNT_WIDE,
  input wire logic        O_ALARM_SEND
);
  logic [31:0] ctrl_r;
  logic [15:0] intv_r;
  logic [2:0]  age_r;
  logic        wr_ok;
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RSTN);
  assign wr_ok = I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK && I_WB_SEL == 4'hf;
  // age_r saturates so that sends queued before a mode change are not judged
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl_r <= `WTC_CTRL_RST;
      age_r  <= 3'h7;
    end else if (wr_ok && I_WB_ADR == `WTC_OFF_CTRL) begin
      ctrl_r <= I_WB_DAT;
      age_r  <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      intv_r <= `WTC_INTERVAL_RST;
    end else if (wr_ok && I_WB_ADR == `WTC_OFF_INTERVAL && I_WB_DAT[15:0] != 16'h0) begin
      intv_r <= I_WB_DAT[15:0];
    end
  end
  ack_follows_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  reset_quiet_a: assert property ($rose(I_RSTN) |-> !O_WB_ACK && !O_CNT_SEND && !O_ALARM_SEND && !O_IN_READ_REQ)
    else $error("output active at reset release");
  cnt_narrow_a: assert property (O_CNT_SEND |-> O_CNT_VAL[31:16] == 16'h0)
    else $error("sent value above 16 bits");
  never_quiet_a: assert property (age_r == 3'h7 && ctrl_r[9:7] == 3'h0 |-> !O_CNT_SEND)
    else $error("send in never mode");
  intv_mult_a: assert property (O_CNT_SEND && age_r == 3'h7 && ctrl_r[9:7] == 3'h2 && !ctrl_r[10]
    |-> (O_CNT_VAL % intv_r) == 32'h0)
    else $error("interval send off multiple");
  wide_cfg_a: assert property (age_r == 3'h7 |-> O_CNT_WIDE == ctrl_r[5])
    else $error("value width not as configured");
  rdreq_pulse_a: assert property (O_IN_READ_REQ |=> !O_IN_READ_REQ [*2])
    else $error("read request repeated");
  alarm_pulse_a: assert property (O_ALARM_SEND |=> !O_ALARM_SEND)
    else $error("alarm send longer than one cycle");
  cover property (O_CNT_SEND && ctrl_r[9:7] == 3'h2);
  cover property (O_IN_READ_REQ);
  cover property (O_ALARM_SEND);
endmodule : wtc_counter_checker
bind wtc_counter wtc_counter_checker #(.SEC_CYC(SEC_CYC), .WAIT_CYC(WAIT_CYC)) wtc_counter_checker_inst (
  .I_REF_CLK, .I_RSTN, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .I_WB_SEL, .I_WB_DAT, .O_WB_ACK,
  .O_IN_READ_REQ, .O_CNT_SEND, .O_CNT_VAL, .O_CNT_WIDE, .O_ALARM_SEND);
`default_nettype wire

//--- include/wtc_cfg.svh
// working time counter register offsets, field positions, reset values and timing counts
`ifndef WTC_CFG_SVH
`define WTC_CFG_SVH
`define WTC_OFF_CTRL      8'h00
`define WTC_OFF_START     8'h04
`define WTC_OFF_LIMIT     8'h08
`define WTC_OFF_INTERVAL  8'h0c
`define WTC_OFF_CYCLE     8'h10
`define WTC_OFF_ALARMVAL  8'h14
`define WTC_OFF_COUNT     8'h18
`define WTC_OFF_BUSIN     8'h1c
`define WTC_OFF_STATUS    8'h20
`define WTC_OFF_TXVAL     8'h24
// control register fields
`define WTC_C_SRC         0
`define WTC_C_INV         1
`define WTC_C_DIR         2
`define WTC_C_UNIT_LO     3
`define WTC_C_W4          5
`define WTC_C_OVR         6
`define WTC_C_MODE_LO     7
`define WTC_C_SBR         10
`define WTC_C_RSTEN       11
`define WTC_C_RSTSEL_LO   12
`define WTC_C_ALEN        14
`define WTC_C_ALSEL       15
`define WTC_C_INBR_LO     16
`define WTC_C_KEEP        18
`define WTC_C_ITYPE_LO    19
`define WTC_C_START       31
// control: hour unit, off after return, everything else cleared
`define WTC_CTRL_RST      32'h0000_0010
`define WTC_START_RST     16'h2710
`define WTC_LIMIT_RST     16'h03e8
`define WTC_INTERVAL_RST  16'h0001
`define WTC_CYCLE_RST     16'h003c
`define WTC_ALARM_RST     16'h0000
// one second at 250 MHz, in ns
`define WTC_CLK_NS        4
`define WTC_SEC_NS        1000000000
`define WTC_SEC_CYC       (`WTC_SEC_NS / `WTC_CLK_NS)
`define WTC_READ_WAIT_MS  1000
`define WTC_READ_WAIT_CYC (`WTC_READ_WAIT_MS * 1000000 / `WTC_CLK_NS)
`endif

//--- include/wtc_pkg.sv
// working time counter types
package wtc_pkg;
  typedef enum logic [1:0] {WTC_U_SEC = 2'h0, WTC_U_MIN = 2'h1, WTC_U_HOUR = 2'h2} wtc_unit_t;
  typedef enum logic [2:0] {
    WTC_S_NEVER = 3'h0, WTC_S_CHG = 3'h1, WTC_S_INT = 3'h2,
    WTC_S_CYC = 3'h3, WTC_S_CHG_CYC = 3'h4, WTC_S_INT_CYC = 3'h5
  } wtc_send_t;
  typedef enum logic [1:0] {WTC_IB_OFF = 2'h0, WTC_IB_ON = 2'h1, WTC_IB_READ = 2'h2, WTC_IB_KEEP = 2'h3} wtc_inbr_t;
  typedef enum logic [1:0] {WTC_R_OFF = 2'h0, WTC_R_ON = 2'h1, WTC_R_ANY = 2'h2} wtc_rsel_t;
  typedef enum logic [2:0] {WTC_ST_IDLE = 3'b001, WTC_ST_WAIT = 3'b010, WTC_ST_RUN = 3'b100} wtc_state_t;
endpackage : wtc_pkg

//--- rtl/wtc_counter.sv
// working time counter with classic wishbone register slave and bus object ports
//
// Summary of operation
// (RQ1) 1-bit input after bus return: off, on, read from bus, or kept.
// (RQ2) read request unanswered before timeout: input taken as off.
// (RQ3) normal polarity, bus object input: count while object is on.
// (RQ4) inverted polarity, bus object input: count while object is off.
// (RQ5) internal input counts its active state; inverted counts the opposite.
// (RQ6) decrement: load start value, count down to zero.
// (RQ7) increment: load zero, count up to the limit value.
// (RQ8) time unit is second, minute or hour; hour by default.
// (RQ9) start value 1 to 65535, default 10000.
// (RQ10) limit value 1 to 65535, default 1000.
// (RQ11) counter value published as two or four byte unsigned.
// (RQ12) overwrite enabled: received value replaces count; else ignored.
// (RQ13) send never, on change, at intervals, cyclic, or combinations.
// (RQ14) never-send mode still updates and answers read requests.
// (RQ15) interval mode sends only when value is a multiple of interval.
// (RQ16) cyclic modes repeat transmission every cycle time.
// (RQ17) send after bus return enabled and not never: send once at start.
// (RQ18) reset object reloads start value or zero per direction.
// (RQ19) reset trigger value selectable: off, on, or either.
// (RQ20) alarm on elapsed time or on reaching a specific value.
// (RQ21) overwrite above start or limit is clamped to it.
// (RQ22) after bus return: reset counter or restore prior value.
// (RQ23) one step per completed unit while condition holds; stop at end.
`timescale 1ns/100ps
`default_nettype none
`include "wtc_cfg.svh"
module wtc_counter
  import wtc_pkg::*;
#(
  parameter int unsigned SEC_CYC  = `WTC_SEC_CYC,
  parameter int unsigned WAIT_CYC = `WTC_READ_WAIT_CYC
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic             O_WB_ACK,
  output logic [31:0]      O_WB_DAT,
  input  wire logic        I_BUS_RETURN,
  input  wire logic        I_IN_OBJ_WR,
  input  wire logic        I_IN_OBJ_VAL,
  input  wire logic [7:0]  I_INT_INPUTS,
  input  wire logic        I_CNT_OBJ_WR,
  input  wire logic [31:0] I_CNT_OBJ_VAL,
  input  wire logic        I_RST_OBJ_WR,
  input  wire logic        I_RST_OBJ_VAL,
  output logic             O_IN_READ_REQ,
  output logic             O_CNT_SEND,
  output logic [31:0]      O_CNT_VAL,
  output logic             O_CNT_WIDE,
  output logic             O_ALARM_SEND,
  output logic             O_ALARM_VAL
);
  logic [31:0] ctrl_r;
  logic [15:0] start_r, limit_r, intv_r, cyc_r, alval_r;
  logic [15:0] count_r, count_nxt, saved_r;
  logic        in_obj_r, rise_latch_r, int_prev_r, tx_pend_r;
  logic [31:0] sub_r, wait_r;
  logic [12:0] unit_r;
  logic [15:0] cyc_cnt_r;
  logic [7:0]  cyc_sec_r;
  wtc_state_t  state_r;

  wire       src_int  = ctrl_r[`WTC_C_SRC];
  wire       inv      = ctrl_r[`WTC_C_INV];
  wire       dir_up   = ctrl_r[`WTC_C_DIR];
  wire [1:0] unit     = ctrl_r[`WTC_C_UNIT_LO +: 2];
  wire [2:0] mode     = ctrl_r[`WTC_C_MODE_LO +: 3];
  wire [1:0] inbr     = ctrl_r[`WTC_C_INBR_LO +: 2];
  wire [1:0] rsel     = ctrl_r[`WTC_C_RSTSEL_LO +: 2];
  wire [2:0] in_sel   = ctrl_r[`WTC_C_ITYPE_LO +: 3];
  wire [15:0] end_val = dir_up ? limit_r : 16'h0000;
  wire [15:0] ld_val  = dir_up ? 16'h0000 : start_r;
  wire       running  = (state_r == WTC_ST_RUN);
  wire       wb_req   = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  wire       wb_wr    = wb_req && I_WB_WE;
  // a start request or a bus return restarts the function from any state
  wire       restart  = ctrl_r[`WTC_C_START] || I_BUS_RETURN;

  // byte-lane merge, used by every writable register
  function automatic logic [31:0] wtc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : wtc_merge

  // low half of a merged write; a zero result is refused for the timing registers
  function automatic logic [15:0] wtc_merge16(input logic [15:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
    logic [31:0] m;
    m = wtc_merge({16'h0000, old_v}, new_v, sel);
    return m[15:0];
  endfunction : wtc_merge16

  // (RQ21) clamp an incoming value to the configured end
  function automatic logic [15:0] wtc_clamp(input logic [31:0] v, input logic [15:0] top);
    return (v > {16'h0000, top}) ? top : v[15:0];
  endfunction : wtc_clamp

  // configuration registers; the start bit self-clears after one cycle
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl_r  <= `WTC_CTRL_RST;
      start_r <= `WTC_START_RST;
      limit_r <= `WTC_LIMIT_RST;
      intv_r  <= `WTC_INTERVAL_RST;
      cyc_r   <= `WTC_CYCLE_RST;
      alval_r <= `WTC_ALARM_RST;
    end else begin
      ctrl_r[`WTC_C_START] <= 1'b0;
      // writes take effect on the edge at which the request is taken
      if (wb_wr) begin
        case (I_WB_ADR)
          `WTC_OFF_CTRL:     ctrl_r  <= wtc_merge(ctrl_r, I_WB_DAT, I_WB_SEL);
          // (RQ9) zero is not a legal start value
          `WTC_OFF_START:    if (wtc_merge16(start_r, I_WB_DAT, I_WB_SEL) != 16'h0000) begin
            start_r <= wtc_merge16(start_r, I_WB_DAT, I_WB_SEL);
          end
          // (RQ10) zero is not a legal limit value
          `WTC_OFF_LIMIT:    if (wtc_merge16(limit_r, I_WB_DAT, I_WB_SEL) != 16'h0000) begin
            limit_r <= wtc_merge16(limit_r, I_WB_DAT, I_WB_SEL);
          end
          // a zero interval would make every value a multiple and divide by zero
          `WTC_OFF_INTERVAL: if (wtc_merge16(intv_r, I_WB_DAT, I_WB_SEL) != 16'h0000) begin
            intv_r <= wtc_merge16(intv_r, I_WB_DAT, I_WB_SEL);
          end
          `WTC_OFF_CYCLE:    if (wtc_merge16(cyc_r, I_WB_DAT, I_WB_SEL) != 16'h0000) begin
            cyc_r <= wtc_merge16(cyc_r, I_WB_DAT, I_WB_SEL);
          end
          `WTC_OFF_ALARMVAL: alval_r <= wtc_merge16(alval_r, I_WB_DAT, I_WB_SEL);
          default: ;
        endcase
      end
    end
  end

  // wishbone answer: one wait state, unmapped reads return zero
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
    end else begin
      // ack is masked out of wb_req, so it never stands two cycles
      O_WB_ACK <= wb_req;
      if (wb_req && !I_WB_WE) begin
        case (I_WB_ADR)
          `WTC_OFF_CTRL:     O_WB_DAT <= ctrl_r;
          `WTC_OFF_START:    O_WB_DAT <= {16'h0, start_r};
          `WTC_OFF_LIMIT:    O_WB_DAT <= {16'h0, limit_r};
          `WTC_OFF_INTERVAL: O_WB_DAT <= {16'h0, intv_r};
          `WTC_OFF_CYCLE:    O_WB_DAT <= {16'h0, cyc_r};
          `WTC_OFF_ALARMVAL: O_WB_DAT <= {16'h0, alval_r};
          // (RQ14) count readable in every send mode
          `WTC_OFF_COUNT:    O_WB_DAT <= {16'h0, count_r};
          `WTC_OFF_BUSIN:    O_WB_DAT <= {31'h0, in_obj_r};
          // status: alarm, at end, running, waiting, wide, boot send pending
          `WTC_OFF_STATUS:   O_WB_DAT <= {26'h0, O_ALARM_VAL, (count_r == end_val), running,
                                          state_r == WTC_ST_WAIT, O_CNT_WIDE, tx_pend_r};
          `WTC_OFF_TXVAL:    O_WB_DAT <= O_CNT_VAL;
          default:           O_WB_DAT <= 32'h0;
        endcase
      end
    end
  end

  // start-up sequence: idle until start or bus return, optional wait for read answer
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_r       <= WTC_ST_IDLE;
      wait_r        <= 32'h0;
      in_obj_r      <= 1'b0;
      O_IN_READ_REQ <= 1'b0;
    end else begin
      O_IN_READ_REQ <= 1'b0;
      if (restart) begin
        // (RQ1) pick the input object value after bus return
        case (inbr)
          WTC_IB_OFF:  in_obj_r <= 1'b0;
          WTC_IB_ON:   in_obj_r <= 1'b1;
          WTC_IB_READ: in_obj_r <= 1'b0;
          default:     in_obj_r <= in_obj_r;
        endcase
        if (inbr == WTC_IB_READ && !src_int) begin
          O_IN_READ_REQ <= 1'b1;
          wait_r        <= WAIT_CYC;
          state_r       <= WTC_ST_WAIT;
        end else begin
          state_r <= WTC_ST_RUN;
        end
      end else begin
        case (state_r)
          WTC_ST_IDLE: begin
            if (I_IN_OBJ_WR) begin
              in_obj_r <= I_IN_OBJ_VAL;
            end
          end
          // the wait bounds the read answer; a later answer is taken as a normal telegram
          WTC_ST_WAIT: begin
            wait_r <= wait_r - 32'h1;
            if (I_IN_OBJ_WR) begin
              in_obj_r <= I_IN_OBJ_VAL;
              state_r  <= WTC_ST_RUN;
            end else if (wait_r <= 32'h1) begin
              // (RQ2) no answer: input stays off
              in_obj_r <= 1'b0;
              state_r  <= WTC_ST_RUN;
            end
          end
          WTC_ST_RUN: begin
            if (I_IN_OBJ_WR) begin
              in_obj_r <= I_IN_OBJ_VAL;
            end
          end
          default: state_r <= WTC_ST_IDLE;
        endcase
      end
    end
  end

  // counted condition
  wire int_lvl = I_INT_INPUTS[in_sel];
  // (RQ5) a mains input holds its active state from a rising edge until it falls
  wire int_act = rise_latch_r;
  // (RQ3) normal polarity follows the object, (RQ4) inverted counts it off
  wire cond    = (src_int ? int_act : in_obj_r) ^ inv;

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      int_prev_r   <= 1'b0;
      rise_latch_r <= 1'b0;
    end else begin
      // detector idles low, so an input already high at reset is taken as a rising edge
      int_prev_r   <= int_lvl;
      rise_latch_r <= (int_lvl && !int_prev_r) ? 1'b1 : (int_lvl ? rise_latch_r : 1'b0);
    end
  end

  // (RQ8) unit prescaler: seconds from the clock, then 60 or 3600 seconds
  wire [12:0] unit_len = (unit == WTC_U_SEC) ? 13'd1 : ((unit == WTC_U_MIN) ? 13'd60 : 13'd3600);
  wire sec_tick  = (sub_r == SEC_CYC - 1);
  wire unit_done = sec_tick && (unit_r == unit_len - 13'd1);

  // (RQ23) time only accrues while the condition holds; partial units are kept
  // so that short interruptions of the condition lose no time
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sub_r  <= 32'h0;
      unit_r <= 13'h0;
    end else if (!running || !cond) begin
      sub_r  <= sub_r;
      unit_r <= unit_r;
    end else if (sec_tick) begin
      sub_r  <= 32'h0;
      unit_r <= unit_done ? 13'h0 : unit_r + 13'h1;
    end else begin
      sub_r <= sub_r + 32'h1;
    end
  end

  // a reset telegram outranks an overwrite arriving in the same cycle
  wire rst_hit = I_RST_OBJ_WR && ctrl_r[`WTC_C_RSTEN] &&
                 // (RQ19) off, on or either value triggers
                 ((rsel == WTC_R_ANY) || (rsel == WTC_R_ON && I_RST_OBJ_VAL) ||
                  (rsel == WTC_R_OFF && !I_RST_OBJ_VAL));

  always_comb begin
    count_nxt = count_r;
    if (restart) begin
      // (RQ22) restore reached value or reload
      count_nxt = ctrl_r[`WTC_C_KEEP] ? saved_r : ld_val;
    end else if (rst_hit) begin
      // (RQ18) reload per direction
      count_nxt = ld_val;
    end else if (I_CNT_OBJ_WR && ctrl_r[`WTC_C_OVR]) begin
      // (RQ12) overwrite, (RQ21) clamped
      count_nxt = wtc_clamp(I_CNT_OBJ_VAL, dir_up ? limit_r : start_r);
    end else if (running && cond && unit_done && count_r != end_val) begin
      // (RQ6) down to zero, (RQ7) up to the limit
      count_nxt = dir_up ? count_r + 16'h1 : count_r - 16'h1;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      count_r <= 16'h0;
      saved_r <= 16'h0;
    end else begin
      count_r <= count_nxt;
      // saved_r follows the count while running so a bus return can restore it
      saved_r <= running ? count_r : saved_r;
    end
  end

  // (RQ16) cycle timer in seconds, free-running in cyclic modes
  wire cyc_mode = (mode == WTC_S_CYC) || (mode == WTC_S_CHG_CYC) || (mode == WTC_S_INT_CYC);
  // the cycle timer restarts whenever cyclic sending is switched off
  logic [31:0] cyc_sub_r;
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cyc_sub_r <= 32'h0;
      cyc_cnt_r <= 16'h0;
      cyc_sec_r <= 8'h0;
    end else if (!cyc_mode || !running) begin
      cyc_sub_r <= 32'h0;
      cyc_cnt_r <= 16'h0;
      cyc_sec_r <= 8'h0;
    end else if (cyc_sub_r == SEC_CYC - 1) begin
      cyc_sub_r <= 32'h0;
      cyc_sec_r <= 8'h1;
      cyc_cnt_r <= (cyc_cnt_r >= cyc_r - 16'h1) ? 16'h0 : cyc_cnt_r + 16'h1;
    end else begin
      cyc_sub_r <= cyc_sub_r + 32'h1;
      cyc_sec_r <= 8'h0;
    end
  end
  wire cyc_evt = cyc_mode && running && cyc_sec_r[0] && (cyc_cnt_r == 16'h0);

  wire changed  = (count_nxt != count_r);
  wire chg_mode = (mode == WTC_S_CHG) || (mode == WTC_S_CHG_CYC);
  wire int_mode = (mode == WTC_S_INT) || (mode == WTC_S_INT_CYC);
  // (RQ17) one send at start-up when enabled and mode is not never
  // one cycle late on purpose, so the loaded value is what goes out
  wire boot_tx  = restart && ctrl_r[`WTC_C_SBR] && (mode != WTC_S_NEVER);

  // transmit logic: (RQ13) mode select, (RQ15) multiple of interval
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_CNT_SEND <= 1'b0;
      O_CNT_VAL  <= 32'h0;
      O_CNT_WIDE <= 1'b0;
      tx_pend_r  <= 1'b0;
    end else begin
      // (RQ11) two or four byte publication
      O_CNT_WIDE <= ctrl_r[`WTC_C_W4];
      tx_pend_r  <= boot_tx;
      O_CNT_SEND <= tx_pend_r || (running && changed && (chg_mode ||
                    (int_mode && (count_nxt % intv_r) == 16'h0))) || cyc_evt;
      // upper half stays zero in both widths: the count itself is 16 bits
      O_CNT_VAL  <= {16'h0, count_nxt};
    end
  end

  // (RQ20) alarm on elapsed time or on a specific value
  wire al_hit = ctrl_r[`WTC_C_ALSEL] ? (count_nxt == alval_r) : (count_nxt == end_val);
  // the alarm object pulses only on a change of level, not on every step
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_ALARM_SEND <= 1'b0;
      O_ALARM_VAL  <= 1'b0;
    end else begin
      O_ALARM_SEND <= ctrl_r[`WTC_C_ALEN] && running && changed && (al_hit != O_ALARM_VAL);
      if (ctrl_r[`WTC_C_ALEN] && running && changed) begin
        O_ALARM_VAL <= al_hit;
      end
    end
  end
endmodule : wtc_counter
`default_nettype wire
